/* File: rtl/radio_link_regs_pkg.sv */
package radio_link_regs_pkg;

    // Register byte offsets on the CPU port
    localparam logic [7:0] STATUS_OFFSET = 8'h04;
    localparam logic [7:0] CONFIG_OFFSET = 8'h08;
    localparam logic [7:0] CTRL_INDEX_OFFSET = 8'h0C;
    localparam logic [7:0] TX_CTRL_OFFSET = 8'h14;
    localparam logic [7:0] PHY_LOOP_OFFSET = 8'h24;
    localparam logic [7:0] LCV_THRESH_OFFSET = 8'h50;
    localparam logic [7:0] SYNC_TIME_OFFSET = 8'h54;

    // Status field positions
    localparam int STAT_RX_LOS_BIT = 0;
    localparam int STAT_RX_STATE_BIT = 1;
    localparam int STAT_HFN_BIT = 2;
    localparam int STAT_BFN_BIT = 3;
    localparam int STAT_LOS_LCV_BIT = 5;
    localparam int STAT_LOS_HOLD_BIT = 8;
    localparam int STAT_STATE_HOLD_BIT = 9;
    localparam int STAT_FREQ_HOLD_BIT = 10;
    localparam int STAT_RFP_HOLD_BIT = 11;

    // Configuration field positions
    localparam int CFG_INSERT_BIT = 0;
    localparam int CFG_LOOP_LSB = 2;
    localparam int CFG_LOOP_MSB = 4;
    localparam int CFG_TX_EN_BIT = 5;

    // Transmit control word fields
    localparam int TXC_INSERT_BIT = 8;
    localparam int TXC_DATA_MSB = 7;

    // Other fields
    localparam int INDEX_MSB = 7;
    localparam int PHY_LOOP_BIT = 0;

    // Reset values
    localparam logic [31:0] REG_RESET = 32'h0000_0000;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [2:0] LOOP_RESET = 3'h0;

    // Decoder violation limit for loss of signal (count above this)
    localparam logic [4:0] LOS_VIOL_LIMIT = 5'h0F;

    typedef enum logic [2:0] {
        LOOP_NONE = 3'b000,
        LOOP_FULL = 3'b001,
        LOOP_IQ = 3'b010,
        LOOP_CM = 3'b011,
        LOOP_CM_VSS = 3'b100
    } loop_mode_type;

endpackage : radio_link_regs_pkg

/* File: rtl/radio_link_status_config_regs.sv */
`timescale 1ns/1ps
// Overview of operation
// - Status bit 5 flags excessive violations loss
// - Wait timer runs to sync time first
// - Then violations counted up to threshold
// - Status bit 3 shows radio frame sync
// - Status bit 2 shows hyperframe sync
// - Status bit 1 needs all three syncs
// - Status bit 0: violations above fifteen or LOS
// - Config bit 5 enables transmission
// - Hold fields clear on status read
// - Loop select zero means no loopback
// - Mode one returns whole incoming frame
// - Mode two returns IQ, local control
// - Mode three returns control-and-management words
// - Mode four returns C&M and vendor control
// - Loopback only after sync, slave role
// - Physical loop wins over frame loop
// - Config bit 0 globally enables insertion
// - Per-entry insert bit 8, indexed slot
module radio_link_status_config_regs
    import radio_link_regs_pkg::*;
#(
    parameter int DATA_W = 32,
    parameter int SYNC_TIME_W = 24,
    parameter int LCV_THRESH_W = 16
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [7:0] cpuAddr,
    input wire logic cpuRead,
    input wire logic cpuWrite,
    input wire logic [31:0] cpuWriteData,
    output logic [31:0] cpuReadData,
    output logic cpuReadValid,
    input wire logic sfpLos,
    input wire logic lcvEvent,
    input wire logic rxFrameSync,
    input wire logic rxHfnSync,
    input wire logic rxBfnSync,
    input wire logic rxRfpPulse,
    input wire logic freqAlarm,
    input wire logic reSlaveMode,
    input wire logic [DATA_W-1:0] rxData,
    input wire logic rxIsCtrl,
    input wire logic rxIsCm,
    input wire logic rxIsVss,
    input wire logic [DATA_W-1:0] localData,
    input wire logic ctrlSlot,
    input wire logic [7:0] ctrlSlotIndex,
    output logic [DATA_W-1:0] txData,
    output logic txEnable,
    output logic phyLoopEnable,
    output logic rxLos,
    output logic lcvLossAlarm,
    output logic rxSyncState
);

    // Software-written configuration
    logic txEnableCfg;
    logic [2:0] loopMode;
    logic insertAll;
    logic [7:0] ctrlIndex;
    logic txCtrlInsert;
    logic [7:0] txCtrlData;
    logic phyLoop;
    logic [SYNC_TIME_W-1:0] syncTime;
    logic [LCV_THRESH_W-1:0] lcvThresh;
    logic next_txEnableCfg;
    logic [2:0] next_loopMode;
    logic next_insertAll;
    logic [7:0] next_ctrlIndex;
    logic next_txCtrlInsert;
    logic [7:0] next_txCtrlData;
    logic next_phyLoop;
    logic [SYNC_TIME_W-1:0] next_syncTime;
    logic [LCV_THRESH_W-1:0] next_lcvThresh;

    // Configuration writes
    always_comb begin
        next_txEnableCfg = txEnableCfg;
        next_loopMode = loopMode;
        next_insertAll = insertAll;
        next_ctrlIndex = ctrlIndex;
        next_txCtrlInsert = txCtrlInsert;
        next_txCtrlData = txCtrlData;
        next_phyLoop = phyLoop;
        next_syncTime = syncTime;
        next_lcvThresh = lcvThresh;
        if (cpuWrite) begin
            unique case (cpuAddr)
                CONFIG_OFFSET: begin
                    next_txEnableCfg = cpuWriteData[CFG_TX_EN_BIT];
                    next_loopMode =
                        cpuWriteData[CFG_LOOP_MSB:CFG_LOOP_LSB];
                    next_insertAll = cpuWriteData[CFG_INSERT_BIT];
                end
                CTRL_INDEX_OFFSET: begin
                    next_ctrlIndex = cpuWriteData[INDEX_MSB:0];
                end
                TX_CTRL_OFFSET: begin
                    next_txCtrlInsert = cpuWriteData[TXC_INSERT_BIT];
                    next_txCtrlData = cpuWriteData[TXC_DATA_MSB:0];
                end
                PHY_LOOP_OFFSET: begin
                    next_phyLoop = cpuWriteData[PHY_LOOP_BIT];
                end
                LCV_THRESH_OFFSET: begin
                    next_lcvThresh = cpuWriteData[LCV_THRESH_W-1:0];
                end
                SYNC_TIME_OFFSET: begin
                    next_syncTime = cpuWriteData[SYNC_TIME_W-1:0];
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            txEnableCfg <= 1'b0;
            loopMode <= LOOP_RESET;
            insertAll <= 1'b0;
            ctrlIndex <= BYTE_RESET;
            txCtrlInsert <= 1'b0;
            txCtrlData <= BYTE_RESET;
            phyLoop <= 1'b0;
            syncTime <= '0;
            lcvThresh <= '0;
        end else begin
            txEnableCfg <= next_txEnableCfg;
            loopMode <= next_loopMode;
            insertAll <= next_insertAll;
            ctrlIndex <= next_ctrlIndex;
            txCtrlInsert <= next_txCtrlInsert;
            txCtrlData <= next_txCtrlData;
            phyLoop <= next_phyLoop;
            syncTime <= next_syncTime;
            lcvThresh <= next_lcvThresh;
        end
    end

    // Excessive violation alarm: wait timer, then violation counter
    logic [SYNC_TIME_W-1:0] waitCount;
    logic waitDone;
    logic [LCV_THRESH_W-1:0] lcvCount;
    logic losLcv;
    logic [SYNC_TIME_W-1:0] next_waitCount;
    logic next_waitDone;
    logic [LCV_THRESH_W-1:0] next_lcvCount;
    logic next_losLcv;
    logic lcvRestart;

    assign lcvRestart = cpuWrite
        && (cpuAddr == LCV_THRESH_OFFSET || cpuAddr == SYNC_TIME_OFFSET);

    always_comb begin
        next_waitCount = waitCount;
        next_waitDone = waitDone;
        next_lcvCount = lcvCount;
        next_losLcv = losLcv;
        if (lcvRestart) begin
            next_waitCount = '0;
            next_waitDone = 1'b0;
            next_lcvCount = '0;
            next_losLcv = 1'b0;
        end else if (!waitDone) begin
            if (waitCount >= syncTime) begin
                next_waitDone = 1'b1;
            end else begin
                next_waitCount = waitCount + 1'b1;
            end
        end else if (lcvCount >= lcvThresh) begin
            next_losLcv = 1'b1;
        end else if (lcvEvent) begin
            next_lcvCount = lcvCount + 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            waitCount <= '0;
            waitDone <= 1'b0;
            lcvCount <= '0;
            losLcv <= 1'b0;
        end else begin
            waitCount <= next_waitCount;
            waitDone <= next_waitDone;
            lcvCount <= next_lcvCount;
            losLcv <= next_losLcv;
        end
    end

    // Loss of signal and sync state
    logic losMeta;
    logic losSync;
    logic [4:0] violCount;
    logic losFlag;
    logic stateFlag;
    logic hfnFlag;
    logic bfnFlag;
    logic next_losMeta;
    logic next_losSync;
    logic [4:0] next_violCount;
    logic next_losFlag;
    logic next_stateFlag;
    logic next_hfnFlag;
    logic next_bfnFlag;

    always_comb begin
        next_losMeta = sfpLos;
        next_losSync = losMeta;
        next_violCount = violCount;
        if (rxRfpPulse) begin
            next_violCount = '0;
        end else if (lcvEvent && violCount <= LOS_VIOL_LIMIT) begin
            next_violCount = violCount + 1'b1;
        end
        next_losFlag = losSync || (violCount > LOS_VIOL_LIMIT);
        next_stateFlag = rxFrameSync && rxHfnSync && rxBfnSync;
        next_hfnFlag = rxHfnSync;
        next_bfnFlag = rxBfnSync;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            losMeta <= 1'b0;
            losSync <= 1'b0;
            violCount <= '0;
            losFlag <= 1'b0;
            stateFlag <= 1'b0;
            hfnFlag <= 1'b0;
            bfnFlag <= 1'b0;
        end else begin
            losMeta <= next_losMeta;
            losSync <= next_losSync;
            violCount <= next_violCount;
            losFlag <= next_losFlag;
            stateFlag <= next_stateFlag;
            hfnFlag <= next_hfnFlag;
            bfnFlag <= next_bfnFlag;
        end
    end

    // Hold fields, cleared by a status read; a new event wins
    logic [3:0] holds;
    logic [3:0] next_holds;
    logic [3:0] holdEvents;
    logic statusRead;

    assign statusRead = cpuRead && cpuAddr == STATUS_OFFSET;
    assign holdEvents = {rxRfpPulse, freqAlarm, !stateFlag, losFlag};

    always_comb begin
        next_holds = (statusRead ? 4'h0 : holds) | holdEvents;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            holds <= 4'h0;
        end else begin
            holds <= next_holds;
        end
    end

    // Register reads
    logic [31:0] next_cpuReadData;
    logic [31:0] statusWord;
    logic [31:0] configWord;

    always_comb begin
        statusWord = REG_RESET;
        statusWord[STAT_RX_LOS_BIT] = losFlag;
        statusWord[STAT_RX_STATE_BIT] = stateFlag;
        statusWord[STAT_HFN_BIT] = hfnFlag;
        statusWord[STAT_BFN_BIT] = bfnFlag;
        statusWord[STAT_LOS_LCV_BIT] = losLcv;
        statusWord[STAT_LOS_HOLD_BIT] = holds[0];
        statusWord[STAT_STATE_HOLD_BIT] = holds[1];
        statusWord[STAT_FREQ_HOLD_BIT] = holds[2];
        statusWord[STAT_RFP_HOLD_BIT] = holds[3];
        configWord = REG_RESET;
        configWord[CFG_TX_EN_BIT] = txEnableCfg;
        configWord[CFG_LOOP_MSB:CFG_LOOP_LSB] = loopMode;
        configWord[CFG_INSERT_BIT] = insertAll;
        next_cpuReadData = REG_RESET;
        if (cpuRead) begin
            unique case (cpuAddr)
                STATUS_OFFSET: next_cpuReadData = statusWord;
                CONFIG_OFFSET: next_cpuReadData = configWord;
                CTRL_INDEX_OFFSET: next_cpuReadData[INDEX_MSB:0] = ctrlIndex;
                TX_CTRL_OFFSET: begin
                    next_cpuReadData[TXC_INSERT_BIT] = txCtrlInsert;
                    next_cpuReadData[TXC_DATA_MSB:0] = txCtrlData;
                end
                PHY_LOOP_OFFSET: next_cpuReadData[PHY_LOOP_BIT] = phyLoop;
                LCV_THRESH_OFFSET:
                    next_cpuReadData[LCV_THRESH_W-1:0] = lcvThresh;
                SYNC_TIME_OFFSET:
                    next_cpuReadData[SYNC_TIME_W-1:0] = syncTime;
                default: next_cpuReadData = REG_RESET;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            cpuReadData <= REG_RESET;
            cpuReadValid <= 1'b0;
        end else begin
            cpuReadData <= next_cpuReadData;
            cpuReadValid <= cpuRead;
        end
    end

    // Transmit word selection ahead of the framer output
    logic loopActive;
    logic takeRx;
    logic insertHit;
    logic [DATA_W-1:0] next_txData;
    logic next_txEnable;

    always_comb begin
        loopActive = loopMode != LOOP_NONE && stateFlag && reSlaveMode
            && !phyLoop;
        takeRx = 1'b0;
        if (loopActive) begin
            unique case (loop_mode_type'(loopMode))
                LOOP_FULL: takeRx = 1'b1;
                LOOP_IQ: takeRx = !rxIsCtrl;
                LOOP_CM: takeRx = rxIsCm;
                LOOP_CM_VSS:
                    takeRx = rxIsCtrl && (rxIsCm || rxIsVss);
                default: takeRx = 1'b0;
            endcase
        end
        insertHit = ctrlSlot && ctrlSlotIndex == ctrlIndex
            && (insertAll || txCtrlInsert);
        next_txData = localData;
        if (!txEnableCfg) begin
            next_txData = '0;
        end else if (takeRx) begin
            next_txData = rxData;
        end else if (insertHit) begin
            next_txData[7:0] = txCtrlData;
        end
        next_txEnable = txEnableCfg;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            txData <= '0;
            txEnable <= 1'b0;
        end else begin
            txData <= next_txData;
            txEnable <= next_txEnable;
        end
    end

    assign phyLoopEnable = phyLoop;
    assign rxLos = losFlag;
    assign lcvLossAlarm = losLcv;
    assign rxSyncState = stateFlag;

endmodule : radio_link_status_config_regs

/* File: tb/radio_link_status_config_regs_props.sv */
`timescale 1ns/1ps
module radio_link_checker
    import radio_link_regs_pkg::*;
#(
    parameter int DATA_W = 32
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [7:0] cpuAddr,
    input wire logic cpuRead,
    input wire logic cpuWrite,
    input wire logic [31:0] cpuWriteData,
    input wire logic [31:0] cpuReadData,
    input wire logic cpuReadValid,
    input wire logic sfpLos,
    input wire logic rxFrameSync,
    input wire logic rxHfnSync,
    input wire logic rxBfnSync,
    input wire logic [DATA_W-1:0] txData,
    input wire logic txEnable,
    input wire logic phyLoopEnable,
    input wire logic rxLos,
    input wire logic lcvLossAlarm,
    input wire logic rxSyncState
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);
    a_idle_data_zero: assert property (
        !cpuReadValid |-> cpuReadData == 32'h0) else $error("read data not idle");
    a_status_reserved: assert property (
        cpuRead && cpuAddr == STATUS_OFFSET
        |=> cpuReadValid && (cpuReadData & 32'hFFFF_F0D0) == 32'h0)
        else $error("status reserved bits set");
    a_config_read_back: assert property (
        cpuWrite && cpuAddr == CONFIG_OFFSET ##2 cpuRead
        && cpuAddr == CONFIG_OFFSET
        |=> cpuReadData == ($past(cpuWriteData, 3) & 32'h0000_003D))
        else $error("config read back wrong");
    a_sync_all_three: assert property (
        !$past(rst) |-> rxSyncState
        == $past(rxFrameSync && rxHfnSync && rxBfnSync))
        else $error("sync state wrong");
    a_los_from_pin: assert property (
        sfpLos [*4] |-> rxLos) else $error("pin loss not shown");
    a_tx_off_quiet: assert property (
        !txEnable |-> txData == '0) else $error("data sent while disabled");
    a_alarm_sticky: assert property (
        lcvLossAlarm && !(cpuWrite && (cpuAddr == LCV_THRESH_OFFSET
        || cpuAddr == SYNC_TIME_OFFSET)) |=> lcvLossAlarm)
        else $error("alarm dropped");
    a_phy_loop_write: assert property (
        cpuWrite && cpuAddr == PHY_LOOP_OFFSET
        |=> phyLoopEnable == $past(cpuWriteData[0]))
        else $error("phy loop not written");
    c_los_seen: cover property (rxLos);
    c_alarm_seen: cover property ($rose(lcvLossAlarm));
    c_sync_seen: cover property ($rose(rxSyncState));
endmodule : radio_link_checker

/* File: tb/radio_link_status_config_regs_test.sv */
`timescale 1ns/1ps
module radio_link_status_config_regs_test;
    import radio_link_regs_pkg::*;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] cpuAddr = 8'h00;
    logic cpuRead = 1'b0;
    logic cpuWrite = 1'b0;
    logic [31:0] cpuWriteData = 32'h0;
    logic sfpLos = 1'b0;
    logic freqAlarm = 1'b0;
    logic violOn = 1'b0;
    logic frameTick = 1'b0;
    logic syncUp = 1'b0;
    logic reSlaveMode = 1'b0;
    logic ctrlSlot = 1'b0;
    logic [7:0] ctrlSlotIndex = 8'h00;
    logic [31:0] localData = 32'h0F0F_0F0F;
    logic lcvEvent, rxFrameSync, rxHfnSync, rxBfnSync, rxRfpPulse, cpuReadValid;
    logic rxIsCtrl, rxIsCm, rxIsVss, txEnable, phyLoopEnable, pC, pM, pV;
    logic rxLos, lcvLossAlarm, rxSyncState;
    logic [31:0] rxData, txData, pRx, rd, cpuReadData;
    int fail_count = 0;
    int comparisons = 0;
    int cycles = 0;
    radio_link_status_config_regs radio_link_status_config_regs_inst (
        .mclk(mclk), .rst(rst), .cpuAddr(cpuAddr), .cpuRead(cpuRead),
        .cpuWrite(cpuWrite), .cpuWriteData(cpuWriteData),
        .cpuReadData(cpuReadData), .cpuReadValid(cpuReadValid),
        .sfpLos(sfpLos), .lcvEvent(lcvEvent), .rxFrameSync(rxFrameSync),
        .rxHfnSync(rxHfnSync), .rxBfnSync(rxBfnSync),
        .rxRfpPulse(rxRfpPulse), .freqAlarm(freqAlarm),
        .reSlaveMode(reSlaveMode), .rxData(rxData), .rxIsCtrl(rxIsCtrl),
        .rxIsCm(rxIsCm), .rxIsVss(rxIsVss), .localData(localData),
        .ctrlSlot(ctrlSlot), .ctrlSlotIndex(ctrlSlotIndex),
        .txData(txData), .txEnable(txEnable),
        .phyLoopEnable(phyLoopEnable), .rxLos(rxLos),
        .lcvLossAlarm(lcvLossAlarm), .rxSyncState(rxSyncState));
    remote_node_model remote_node_model_inst (
        .mclk(mclk), .syncUp(syncUp), .violOn(violOn),
        .frameTick(frameTick), .rxFrameSync(rxFrameSync),
        .rxHfnSync(rxHfnSync), .rxBfnSync(rxBfnSync), .lcvEvent(lcvEvent),
        .rxRfpPulse(rxRfpPulse), .rxData(rxData), .rxIsCtrl(rxIsCtrl),
        .rxIsCm(rxIsCm), .rxIsVss(rxIsVss));
    initial begin
        forever #2 mclk = ~mclk;
    end
    task automatic complete_run();
        if (fail_count == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : complete_run
    always @(posedge mclk) begin
        pRx <= rxData;
        pC <= rxIsCtrl;
        pM <= rxIsCm;
        pV <= rxIsVss;
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            fail_count++;
            complete_run();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic idle(input int n);
        repeat (n) @(negedge mclk);
    endtask : idle
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(negedge mclk);
        cpuAddr = a;
        cpuWriteData = d;
        cpuWrite = 1'b1;
        @(negedge mclk);
        cpuWrite = 1'b0;
    endtask : wr
    task automatic rdreg(input logic [7:0] a);
        @(negedge mclk);
        cpuAddr = a;
        cpuRead = 1'b1;
        @(negedge mclk);
        cpuRead = 1'b0;
        rd = cpuReadData;
        check({31'h0, cpuReadValid}, 32'h1);
    endtask : rdreg
    task automatic viol(input int n);
        violOn = 1'b1;
        idle(n);
        violOn = 1'b0;
        idle(3);
    endtask : viol
    task automatic ins(input logic [31:0] c, t, input logic [7:0] b);
        wr(CONFIG_OFFSET, c);
        wr(TX_CTRL_OFFSET, t);
        idle(2);
        check(txData, {localData[31:8], b});
    endtask : ins
    function automatic logic [31:0] loopExp(input logic [2:0] m);
        logic take;
        case (m)
            3'b001: take = 1'b1;
            3'b010: take = !pC;
            3'b011: take = pM;
            3'b100: take = pC && (pM || pV);
            default: take = 1'b0;
        endcase
        return take ? pRx : localData;
    endfunction : loopExp
    initial begin
        idle(2);
        rst = 1'b0;
        rdreg(STATUS_OFFSET);
        check(rd & 32'h0000_00FF, REG_RESET);
        rdreg(CONFIG_OFFSET);
        check(rd, REG_RESET);
        wr(CONFIG_OFFSET, 32'hFFFF_FFFF);
        rdreg(CONFIG_OFFSET);
        check(rd, 32'h0000_003D);
        rdreg(8'h60);
        check(rd, REG_RESET);
        wr(CONFIG_OFFSET, REG_RESET);
        idle(2);
        check(txData, REG_RESET);
        check({31'h0, txEnable}, 32'h0);
        syncUp = 1'b1;
        idle(3);
        rdreg(STATUS_OFFSET);
        check(rd & 32'h0000_020F, 32'h0000_020E);
        rdreg(STATUS_OFFSET);
        check(rd, 32'h0000_002E);
        sfpLos = 1'b1;
        freqAlarm = 1'b1;
        idle(5);
        check({31'h0, rxLos}, 32'h1);
        sfpLos = 1'b0;
        freqAlarm = 1'b0;
        idle(5);
        rdreg(STATUS_OFFSET);
        check(rd, 32'h0000_052E);
        wr(SYNC_TIME_OFFSET, 32'h0000_0014);
        wr(LCV_THRESH_OFFSET, 32'h0000_0005);
        viol(10);
        idle(25);
        viol(4);
        check({31'h0, lcvLossAlarm}, 32'h0);
        viol(1);
        check({31'h0, lcvLossAlarm}, 32'h1);
        check({31'h0, rxLos}, 32'h0);
        viol(1);
        check({31'h0, rxLos}, 32'h1);
        frameTick = 1'b1;
        idle(1);
        frameTick = 1'b0;
        idle(3);
        check({31'h0, rxLos}, 32'h0);
        rdreg(STATUS_OFFSET);
        check(rd & 32'h0000_0F2F, 32'h0000_092E);
        reSlaveMode = 1'b1;
        for (int m = 0; m < 6; m++) begin
            wr(CONFIG_OFFSET, 32'h20 | (32'(m) << 2));
            idle(2);
            check({31'h0, txEnable}, 32'h1);
            repeat (8) begin
                @(negedge mclk);
                rd = loopExp(3'(m));
                check(txData, rd);
            end
        end
        wr(CONFIG_OFFSET, 32'h0000_0024);
        reSlaveMode = 1'b0;
        idle(2);
        check(txData, localData);
        reSlaveMode = 1'b1;
        idle(2);
        check(txData, pRx);
        syncUp = 1'b0;
        idle(3);
        check(txData, localData);
        syncUp = 1'b1;
        wr(PHY_LOOP_OFFSET, 32'h1);
        idle(3);
        check(txData, localData);
        check({31'h0, phyLoopEnable}, 32'h1);
        wr(PHY_LOOP_OFFSET, REG_RESET);
        wr(CTRL_INDEX_OFFSET, 32'h3);
        ctrlSlot = 1'b1;
        ctrlSlotIndex = 8'h03;
        ins(32'h21, 32'h05A, 8'h5A);
        ins(32'h20, 32'h15A, 8'h5A);
        ins(32'h20, 32'h05A, 8'h0F);
        complete_run();
    end
endmodule : radio_link_status_config_regs_test
bind radio_link_status_config_regs radio_link_checker #(.DATA_W(DATA_W))
    radio_link_checker_inst (.mclk(mclk), .rst(rst), .cpuAddr(cpuAddr),
    .cpuRead(cpuRead), .cpuWrite(cpuWrite), .cpuWriteData(cpuWriteData),
    .cpuReadData(cpuReadData), .cpuReadValid(cpuReadValid), .sfpLos(sfpLos),
    .rxFrameSync(rxFrameSync), .rxHfnSync(rxHfnSync), .rxBfnSync(rxBfnSync),
    .txData(txData), .txEnable(txEnable), .phyLoopEnable(phyLoopEnable),
    .rxLos(rxLos), .lcvLossAlarm(lcvLossAlarm), .rxSyncState(rxSyncState));

/* File: tb/remote_node_model.sv */
`timescale 1ns/1ps
module remote_node_model (
    input wire logic mclk,
    input wire logic syncUp,
    input wire logic violOn,
    input wire logic frameTick,
    output logic rxFrameSync,
    output logic rxHfnSync,
    output logic rxBfnSync,
    output logic lcvEvent,
    output logic rxRfpPulse,
    output logic [31:0] rxData,
    output logic rxIsCtrl,
    output logic rxIsCm,
    output logic rxIsVss
);
    logic [7:0] k = 8'h00;
    always @(negedge mclk) begin
        k <= k + 8'h01;
    end
    assign rxData = {8'hA5, k, k, ~k};
    assign rxIsCtrl = k[0];
    assign rxIsCm = k[1];
    assign rxIsVss = k[2];
    assign rxFrameSync = syncUp;
    assign rxHfnSync = syncUp;
    assign rxBfnSync = syncUp;
    assign lcvEvent = violOn;
    assign rxRfpPulse = frameTick;
endmodule : remote_node_model
